// file: include/scd_defines.svh
// Command codes, phase codes and timing constants of the target dispatcher
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH

`define SCD_C_RECV_NCMD 8'h28
`define SCD_C_RECV_NMSG 8'h29
`define SCD_C_RESEL_NTERM 8'h2A
`define SCD_C_RESEL_NLINK 8'h2B
`define SCD_C_DISC_SEQ2 8'h2C
`define SCD_C_RESEL 8'h30
`define SCD_C_SET_REQ 8'h31
`define SCD_C_CLR_REQ 8'h32
`define SCD_C_DISCONNECT 8'h33
`define SCD_C_SEND_PIO 8'h34
`define SCD_C_SEND_DMA 8'h35
`define SCD_C_RECV_PIO 8'h36
`define SCD_C_RECV_DMA 8'h37
`define SCD_C_SEND_MSG 8'h38
`define SCD_C_RECV_MSG 8'h39
`define SCD_C_SEND_STAT 8'h3A
`define SCD_C_RECV_CDB 8'h3B
`define SCD_C_SW_RESET 8'h40
`define SCD_C_XFER_RESET 8'h41
`define SCD_C_BUS_RESET 8'h42
`define SCD_C_SETUP 8'h43
`define SCD_C_INIT_DIAG 8'h44
`define SCD_C_TARG_DIAG 8'h45
`define SCD_C_SELFTEST_EXIT 8'h46
`define SCD_C_PAUSE 8'h47
`define SCD_C_HOLD_RST 8'h48
`define SCD_C_FREE_RST 8'h49

// Bus phase as {msg, c/d, i/o}
`define SCD_PH_DOUT 3'h0
`define SCD_PH_DIN 3'h1
`define SCD_PH_CMD 3'h2
`define SCD_PH_STAT 3'h3
`define SCD_PH_MOUT 3'h6
`define SCD_PH_MIN 3'h7

`define SCD_DIAG_OFF 2'h0
`define SCD_DIAG_INIT 2'h1
`define SCD_DIAG_TARG 2'h2

`define SCD_MCLK_MHZ 200
`define SCD_BUS_RST_NS 25000
`define SCD_FIFO_DEPTH 8
`define SCD_FIFO_WIDTH 8

`endif

// file: include/scd_pkg.sv
// Types shared by the target command dispatcher
package scd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_RESEL = 3'b010,
    ST_REQ = 3'b011,
    ST_ACK = 3'b100
  } scd_state_e;

  typedef enum logic [2:0] {
    K_END = 3'b000,
    K_RESEL = 3'b001,
    K_SEND = 3'b010,
    K_RECV = 3'b011,
    K_DISC = 3'b100
  } scd_kind_e;

  typedef enum logic [1:0] {
    N_ONE = 2'b00,
    N_MC = 2'b01,
    N_DATA = 2'b10,
    N_CDB = 2'b11
  } scd_cnt_e;

  typedef struct packed {
    scd_kind_e kind;
    logic [2:0] phase;
    scd_cnt_e cnt;
  } scd_seg_s;
endpackage

// file: include/scd_fifo_if.sv
// Valid/ready carrier between the dispatcher and its outgoing byte FIFO
`timescale 1ns/1ps
interface scd_fifo_if #(parameter int W = 8);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  logic clr;
  modport fifo(input wr_valid, input wr_data, input rd_ready, input clr,
               output wr_ready, output rd_valid, output rd_data);
  modport user(output wr_valid, output wr_data, output rd_ready, output clr,
               input wr_ready, input rd_valid, input rd_data);
endinterface

// file: hdl/scd_fifo.sv
// Parameterised first-word-fall-through byte FIFO
`timescale 1ns/1ps
module scd_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic mclk,
  input wire logic rst,
  scd_fifo_if.fifo f
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW+1)'(D);

  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign f.wr_ready = (cnt_q != FULL);
  assign f.rd_valid = (cnt_q != '0);
  assign f.rd_data = mem_q[rp_q];
  assign push = f.wr_valid && f.wr_ready && !f.clr;
  assign pop = f.rd_valid && f.rd_ready && !f.clr;

  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (f.clr) begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
    end else begin
      if (push) begin
        wp_d = (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_d = (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage needs no reset; valid is tracked by the count
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wp_q] <= f.wr_data;
    end
  end
endmodule

// file: hdl/scd_dispatch.sv
// Target command decoder and bus phase sequencer
`timescale 1ns/1ps
`include "scd_defines.svh"

module scd_dispatch
  import scd_pkg::*;
#(
  parameter int unsigned RST_CYCLES = `SCD_BUS_RST_NS * `SCD_MCLK_MHZ / 1000
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] msg_cmd_byte_count,
  input wire logic [2:0] target_peer_identifier,
  input wire logic [7:0] data_block_count,
  input wire logic [7:0] data_byte_count,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic dma_valid,
  input wire logic [7:0] dma_data,
  output logic dma_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_to_dma,
  input wire logic bus_ack,
  input wire logic bus_resel_ack,
  input wire logic [7:0] bus_data_in,
  output logic bus_req,
  output logic bus_bsy,
  output logic bus_resel,
  output logic [2:0] bus_resel_id,
  output logic [2:0] bus_phase,
  output logic [7:0] bus_data_out,
  output logic bus_data_oe,
  output logic bus_rst,
  output logic busy,
  output logic halted,
  output logic cmd_done,
  output logic cmd_reject,
  output logic pause_done,
  output logic setup_valid,
  output logic [1:0] diag_mode
);
  ////////////////////////////////////////////////////////////////////////////
  scd_fifo_if #(.W(`SCD_FIFO_WIDTH)) fq ();

  scd_fifo #(.W(`SCD_FIFO_WIDTH), .D(`SCD_FIFO_DEPTH)) scd_fifo_i (
    .mclk(mclk),
    .rst(rst),
    .f(fq)
  );

  logic ack_m_q, ack_s_q, rack_m_q, rack_s_q;
  logic [7:0] din_m_q, din_s_q;

  // Bus inputs come from another domain
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
      rack_m_q <= 1'b0;
      rack_s_q <= 1'b0;
      din_m_q <= 8'h00;
      din_s_q <= 8'h00;
    end else begin
      ack_m_q <= bus_ack;
      ack_s_q <= ack_m_q;
      rack_m_q <= bus_resel_ack;
      rack_s_q <= rack_m_q;
      din_m_q <= bus_data_in;
      din_s_q <= din_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic scd_seg_s seg_of(input logic [7:0] c, input logic [2:0] s);
    scd_seg_s g;
    g = '{kind: K_END, phase: `SCD_PH_DOUT, cnt: N_ONE};
    case (c)
      `SCD_C_RECV_NCMD: if (s == 3'h0) g = '{K_RECV, `SCD_PH_CMD, N_MC};
      `SCD_C_RECV_NMSG: if (s == 3'h0) g = '{K_RECV, `SCD_PH_MOUT, N_MC};
      `SCD_C_RESEL_NTERM, `SCD_C_RESEL_NLINK: begin
        case (s)
          3'h0: g = '{K_RESEL, `SCD_PH_MIN, N_ONE};
          3'h1: g = '{K_SEND, `SCD_PH_MIN, N_MC};
          3'h2: g = '{K_SEND, `SCD_PH_STAT, N_ONE};
          3'h3: g = '{K_SEND, `SCD_PH_MIN, N_ONE};
          3'h4: if (c == `SCD_C_RESEL_NTERM) g = '{K_DISC, `SCD_PH_DOUT, N_ONE};
          default: g.kind = K_END;
        endcase
      end
      `SCD_C_DISC_SEQ2: begin
        if (s == 3'h0) g = '{K_SEND, `SCD_PH_MIN, N_ONE};
        if (s == 3'h1) g = '{K_DISC, `SCD_PH_DOUT, N_ONE};
      end
      `SCD_C_RESEL: if (s == 3'h0) g = '{K_RESEL, `SCD_PH_DOUT, N_ONE};
      `SCD_C_DISCONNECT: if (s == 3'h0) g = '{K_DISC, `SCD_PH_DOUT, N_ONE};
      `SCD_C_SEND_PIO, `SCD_C_SEND_DMA:
        if (s == 3'h0) g = '{K_SEND, `SCD_PH_DIN, N_DATA};
      `SCD_C_RECV_PIO, `SCD_C_RECV_DMA:
        if (s == 3'h0) g = '{K_RECV, `SCD_PH_DOUT, N_DATA};
      `SCD_C_SEND_MSG: if (s == 3'h0) g = '{K_SEND, `SCD_PH_MIN, N_ONE};
      `SCD_C_RECV_MSG: if (s == 3'h0) g = '{K_RECV, `SCD_PH_MOUT, N_ONE};
      `SCD_C_SEND_STAT: if (s == 3'h0) g = '{K_SEND, `SCD_PH_STAT, N_ONE};
      `SCD_C_RECV_CDB: if (s == 3'h0) g = '{K_RECV, `SCD_PH_CMD, N_CDB};
      default: g.kind = K_END;
    endcase
    return g;
  endfunction

  // Remaining bytes after the opcode, by group code
  function automatic logic [15:0] cdb_rest(input logic [7:0] op);
    case (op[7:5])
      3'h1, 3'h2: return 16'h0009;
      3'h5: return 16'h000B;
      default: return 16'h0005;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  scd_state_e st_q, st_d;
  logic [7:0] cmd_q, cmd_d;
  logic [2:0] step_q, step_d;
  logic [15:0] cnt_q, cnt_d;
  logic cdb_q, cdb_d, pause_q, pause_d, halt_q, halt_d;
  logic req_q, req_d, bsy_q, bsy_d, resel_q, resel_d, oe_q, oe_d;
  logic [2:0] rid_q, rid_d, ph_q, ph_d;
  logic [7:0] dout_q, dout_d, rx_q, rx_d;
  logic rxv_q, rxv_d, rxdma_q, rxdma_d, done_q, done_d, rej_q, rej_d;
  logic pdone_q, pdone_d, setup_q, setup_d, hold_q, hold_d, brst_q, brst_d;
  logic [1:0] diag_q, diag_d;
  logic [15:0] rcnt_q, rcnt_d;
  logic src_dma_q, src_dma_d, busy_q, busy_d, clr;
  scd_seg_s seg;
  logic is_seq, is_com, is_send, data_ph;

  assign seg = seg_of(cmd_q, step_q);
  assign is_send = (seg.kind == K_SEND);
  assign is_seq = (cmd_code >= `SCD_C_RECV_NCMD && cmd_code <= `SCD_C_DISC_SEQ2) ||
                  (cmd_code >= `SCD_C_RESEL && cmd_code <= `SCD_C_RECV_CDB);
  assign is_com = cmd_code >= `SCD_C_SW_RESET && cmd_code <= `SCD_C_FREE_RST;
  assign data_ph = (st_q == ST_REQ || st_q == ST_ACK) &&
                   (seg.phase == `SCD_PH_DIN || seg.phase == `SCD_PH_DOUT);

  // Outgoing bytes come from the host port, or from DMA for 35h
  assign fq.wr_valid = src_dma_q ? dma_valid : tx_valid;
  assign fq.wr_data = src_dma_q ? dma_data : tx_data;
  assign tx_ready = fq.wr_ready && !src_dma_q;
  assign dma_ready = fq.wr_ready && src_dma_q;
  assign fq.rd_ready = (st_q == ST_REQ) && is_send && !req_q;
  assign fq.clr = clr;

  always_comb begin
    st_d = st_q; cmd_d = cmd_q; step_d = step_q; cnt_d = cnt_q;
    cdb_d = cdb_q; pause_d = pause_q; halt_d = halt_q;
    req_d = req_q; bsy_d = bsy_q; resel_d = resel_q; oe_d = oe_q;
    rid_d = rid_q; ph_d = ph_q; dout_d = dout_q; rx_d = rx_q;
    rxv_d = 1'b0; rxdma_d = rxdma_q; done_d = 1'b0; rej_d = 1'b0;
    pdone_d = 1'b0; setup_d = 1'b0; hold_d = hold_q; diag_d = diag_q;
    rcnt_d = (rcnt_q != 16'h0000) ? rcnt_q - 16'h0001 : 16'h0000;
    src_dma_d = src_dma_q; clr = 1'b0;
    case (st_q)
      ST_IDLE: begin
        src_dma_d = 1'b0;
        if (cmd_valid && is_seq && !halt_q) begin
          cmd_d = cmd_code; step_d = 3'h0; pause_d = 1'b0;
          src_dma_d = (cmd_code == `SCD_C_SEND_DMA);
          rxdma_d = (cmd_code == `SCD_C_RECV_DMA);
          st_d = ST_LOAD;
          if (cmd_code == `SCD_C_SET_REQ || cmd_code == `SCD_C_CLR_REQ) begin
            req_d = (cmd_code == `SCD_C_SET_REQ);
            done_d = 1'b1;
            st_d = ST_IDLE;
          end
        end
      end
      ST_LOAD: begin
        case (seg.kind)
          K_RESEL: begin
            resel_d = 1'b1; rid_d = target_peer_identifier; ph_d = seg.phase;
            st_d = ST_RESEL;
          end
          K_DISC: begin
            bsy_d = 1'b0; ph_d = `SCD_PH_DOUT; step_d = step_q + 3'h1;
          end
          K_SEND, K_RECV: begin
            ph_d = seg.phase; cdb_d = (seg.cnt == N_CDB); st_d = ST_REQ;
            case (seg.cnt)
              N_MC: cnt_d = {8'h00, msg_cmd_byte_count};
              N_DATA: cnt_d = {data_block_count, data_byte_count};
              default: cnt_d = 16'h0001;
            endcase
            if (cnt_d == 16'h0000) begin
              step_d = step_q + 3'h1; st_d = ST_LOAD;
            end
          end
          default: begin
            done_d = 1'b1; st_d = ST_IDLE;
          end
        endcase
      end
      ST_RESEL: begin
        if (rack_s_q) begin
          resel_d = 1'b0; bsy_d = 1'b1; step_d = step_q + 3'h1; st_d = ST_LOAD;
        end
      end
      ST_REQ: begin
        if (!req_q) begin
          if (!is_send) begin
            req_d = 1'b1;
          end else if (fq.rd_valid) begin
            // Data settles with REQ; the initiator samples on ACK
            dout_d = fq.rd_data; oe_d = 1'b1; req_d = 1'b1;
          end
        end else if (ack_s_q) begin
          req_d = 1'b0; st_d = ST_ACK;
          if (!is_send) begin
            rx_d = din_s_q; rxv_d = 1'b1;
            if (cdb_q) begin
              cdb_d = 1'b0; cnt_d = cdb_rest(din_s_q) + 16'h0001;
            end
          end
        end
      end
      ST_ACK: begin
        if (!ack_s_q) begin
          oe_d = 1'b0; cnt_d = cnt_q - 16'h0001;
          st_d = ST_REQ;
          if (pause_q) begin
            pause_d = 1'b0; pdone_d = 1'b1; st_d = ST_IDLE;
          end else if (cnt_d == 16'h0000) begin
            step_d = step_q + 3'h1; st_d = ST_LOAD;
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // Common commands take effect in any state; while halted only 40h is taken, the others are rejected
    if (cmd_valid && is_com) begin
      if (halt_q && cmd_code != `SCD_C_SW_RESET) begin
        rej_d = 1'b1;
      end else begin
        done_d = 1'b1;
        case (cmd_code)
          `SCD_C_SW_RESET: begin
            done_d = 1'b0; halt_d = !halt_q; clr = 1'b1;
            st_d = ST_IDLE; req_d = 1'b0; bsy_d = 1'b0; resel_d = 1'b0;
            oe_d = 1'b0; hold_d = 1'b0; rcnt_d = 16'h0000; diag_d = `SCD_DIAG_OFF;
          end
          `SCD_C_XFER_RESET: begin
            clr = 1'b1; st_d = ST_IDLE; req_d = 1'b0; resel_d = 1'b0; oe_d = 1'b0;
          end
          `SCD_C_BUS_RESET: rcnt_d = 16'(RST_CYCLES);
          `SCD_C_SETUP: setup_d = 1'b1;
          `SCD_C_INIT_DIAG: diag_d = `SCD_DIAG_INIT;
          `SCD_C_TARG_DIAG: diag_d = `SCD_DIAG_TARG;
          `SCD_C_SELFTEST_EXIT: diag_d = `SCD_DIAG_OFF;
          `SCD_C_PAUSE: begin
            // Only a data phase can be paused, at a byte boundary
            done_d = 1'b0;
            if (data_ph) pause_d = 1'b1;
            else pdone_d = 1'b1;
          end
          `SCD_C_HOLD_RST: hold_d = 1'b1;
          `SCD_C_FREE_RST: hold_d = 1'b0;
          default: done_d = 1'b0;
        endcase
      end
    end else if (cmd_valid && !(is_seq && st_q == ST_IDLE && !halt_q)) begin
      rej_d = 1'b1;
    end
    brst_d = hold_d || (rcnt_d != 16'h0000);
    busy_d = (st_d != ST_IDLE);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE; cmd_q <= 8'h00; step_q <= 3'h0; cnt_q <= 16'h0000;
      cdb_q <= 1'b0; pause_q <= 1'b0; halt_q <= 1'b0;
      req_q <= 1'b0; bsy_q <= 1'b0; resel_q <= 1'b0; oe_q <= 1'b0;
      rid_q <= 3'h0; ph_q <= `SCD_PH_DOUT; dout_q <= 8'h00; rx_q <= 8'h00;
      rxv_q <= 1'b0; rxdma_q <= 1'b0; done_q <= 1'b0; rej_q <= 1'b0;
      pdone_q <= 1'b0; setup_q <= 1'b0; hold_q <= 1'b0; brst_q <= 1'b0;
      diag_q <= `SCD_DIAG_OFF; rcnt_q <= 16'h0000; src_dma_q <= 1'b0; busy_q <= 1'b0;
    end else begin
      st_q <= st_d; cmd_q <= cmd_d; step_q <= step_d; cnt_q <= cnt_d;
      cdb_q <= cdb_d; pause_q <= pause_d; halt_q <= halt_d;
      req_q <= req_d; bsy_q <= bsy_d; resel_q <= resel_d; oe_q <= oe_d;
      rid_q <= rid_d; ph_q <= ph_d; dout_q <= dout_d; rx_q <= rx_d;
      rxv_q <= rxv_d; rxdma_q <= rxdma_d; done_q <= done_d; rej_q <= rej_d;
      pdone_q <= pdone_d; setup_q <= setup_d; hold_q <= hold_d; brst_q <= brst_d;
      diag_q <= diag_d; rcnt_q <= rcnt_d; src_dma_q <= src_dma_d; busy_q <= busy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign rx_valid = rxv_q;
  assign rx_data = rx_q;
  assign rx_to_dma = rxdma_q;
  assign bus_req = req_q;
  assign bus_bsy = bsy_q;
  assign bus_resel = resel_q;
  assign bus_resel_id = rid_q;
  assign bus_phase = ph_q;
  assign bus_data_out = dout_q;
  assign bus_data_oe = oe_q;
  assign bus_rst = brst_q;
  assign busy = busy_q;
  assign halted = halt_q;
  assign cmd_done = done_q;
  assign cmd_reject = rej_q;
  assign pause_done = pdone_q;
  assign setup_valid = setup_q;
  assign diag_mode = diag_q;
endmodule

// file: sim/scd_initiator.sv
// Behavioural initiator answering the target's byte requests and reselection
`timescale 1ns/1ps
module scd_initiator (
  input wire logic mclk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [7:0] pat,
  input wire logic bus_req,
  input wire logic bus_resel,
  output logic bus_ack,
  output logic bus_resel_ack,
  output logic [7:0] bus_data_in
);
  int wait_q;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_ack <= 1'b0;
      bus_resel_ack <= 1'b0;
      bus_data_in <= 8'hA5;
      wait_q <= 0;
    end else begin
      bus_resel_ack <= bus_resel;
      if (bus_req == bus_ack) begin
        wait_q <= slow ? 7 : 1;
      end else if (wait_q > 1) begin
        wait_q <= wait_q - 1;
      end else begin
        bus_ack <= bus_req;
        // Released lines show the inverse, never a stale byte
        bus_data_in <= bus_req ? pat : ~bus_data_in;
      end
    end
  end
endmodule

// file: sim/scd_dispatch_sva.sv
// Port-level checker of the target command dispatcher
`timescale 1ns/1ps
module scd_dispatch_sva #(
  parameter int unsigned RST_CYCLES = 5000
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [2:0] target_peer_identifier,
  input wire logic bus_ack,
  input wire logic bus_req,
  input wire logic bus_resel,
  input wire logic [2:0] bus_resel_id,
  input wire logic [2:0] bus_phase,
  input wire logic [7:0] bus_data_out,
  input wire logic bus_data_oe,
  input wire logic bus_rst,
  input wire logic busy,
  input wire logic halted,
  input wire logic cmd_done,
  input wire logic cmd_reject,
  input wire logic setup_valid,
  input wire logic rx_valid
);
  logic [15:0] rc_q;
  logic [7:0] last_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rc_q <= 16'h0000;
      last_q <= 8'h00;
    end else begin
      rc_q <= bus_rst ? rc_q + 16'h0001 : 16'h0000;
      last_q <= cmd_valid ? cmd_code : last_q;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  low_code_a: assert property (
    cmd_valid && cmd_code[7:3] == 5'h04 |-> ##[1:2] cmd_reject) else $error("low code taken");
  busy_refuse_a: assert property (
    cmd_valid && busy && cmd_code inside {[8'h28:8'h2C], [8'h30:8'h3B]} |-> ##[1:2] cmd_reject)
    else $error("command taken while busy");
  halt_quiet_a: assert property (
    cmd_valid && cmd_code == 8'h40 |=> !cmd_done [*3]) else $error("done after soft reset");
  halt_set_a: assert property (
    cmd_valid && cmd_code == 8'h40 && !halted |-> ##[1:2] halted) else $error("no halt");
  halt_block_a: assert property (
    cmd_valid && halted && cmd_code != 8'h40 |-> ##[1:2] cmd_reject) else $error("halt leak");
  drive_in_a: assert property (
    bus_data_oe |-> bus_phase[0]) else $error("driving in an out phase");
  recv_out_a: assert property (
    rx_valid |-> !bus_phase[0]) else $error("receiving in an in phase");
  req_hold_a: assert property (
    bus_req && !bus_ack && !$past(bus_ack) && !$past(bus_ack, 2) && !cmd_valid
    && !$past(cmd_valid) |=> bus_req) else $error("request dropped early");
  data_stable_a: assert property (
    bus_req && $past(bus_req) && bus_data_oe |-> $stable(bus_data_out))
    else $error("data moved under request");
  resel_id_a: assert property (
    bus_resel |-> bus_resel_id == target_peer_identifier) else $error("wrong peer id");
  setup_pulse_a: assert property (
    cmd_valid && !halted && cmd_code == 8'h43 |-> ##[1:2] setup_valid) else $error("no setup");
  rst_len_a: assert property (
    $fell(bus_rst) && last_q == 8'h42 |-> rc_q == RST_CYCLES) else $error("bus reset length");
  cover property (rx_valid);
  cover property (bus_resel);
  cover property (cmd_reject);
  cover property ($rose(halted));
endmodule
bind scd_dispatch scd_dispatch_sva #(.RST_CYCLES(RST_CYCLES)) scd_dispatch_sva_i (.mclk, .rst,
  .cmd_valid, .cmd_code, .target_peer_identifier, .bus_ack, .bus_req, .bus_resel, .bus_resel_id,
  .bus_phase, .bus_data_out, .bus_data_oe, .bus_rst, .busy, .halted, .cmd_done, .cmd_reject,
  .setup_valid, .rx_valid);

// file: sim/test_scsi_target_command_dispatch.sv
// Self-checking bench of the target command dispatcher
`timescale 1ns/1ps
`include "scd_defines.svh"
module test_scsi_target_command_dispatch;
  logic mclk, rst, cmd_valid, tx_valid, dma_valid, slow, tx_ready, dma_ready, rx_valid;
  logic rx_to_dma, bus_ack, bus_resel_ack, bus_req, bus_bsy, bus_resel, bus_data_oe, bus_rst;
  logic busy, halted, cmd_done, cmd_reject, pause_done, setup_valid, req_p, rs_p;
  logic [7:0] cmd_code, msg_cmd_byte_count, data_block_count, data_byte_count, tx_data;
  logic [7:0] dma_data, rx_data, bus_data_in, bus_data_out, pat, b;
  logic [2:0] target_peer_identifier, bus_resel_id, bus_phase;
  logic [1:0] diag_mode;
  logic [11:0] exp_q[$];
  logic [7:0] rej[4] = '{8'h20, 8'h2D, 8'h3C, 8'h4A};
  int fails, num_checks, seed, i, k, n;
  scd_dispatch #(.RST_CYCLES(20)) scd_dispatch_i (.mclk, .rst, .cmd_valid, .cmd_code,
    .msg_cmd_byte_count, .target_peer_identifier, .data_block_count, .data_byte_count,
    .tx_valid, .tx_data, .tx_ready, .dma_valid, .dma_data, .dma_ready, .rx_valid, .rx_data,
    .rx_to_dma, .bus_ack, .bus_resel_ack, .bus_data_in, .bus_req, .bus_bsy, .bus_resel,
    .bus_resel_id, .bus_phase, .bus_data_out, .bus_data_oe, .bus_rst, .busy, .halted,
    .cmd_done, .cmd_reject, .pause_done, .setup_valid, .diag_mode);
  scd_initiator scd_initiator_i (.mclk, .rst, .slow, .pat, .bus_req, .bus_resel, .bus_ack,
    .bus_resel_ack, .bus_data_in);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic summarize;
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (e !== s) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk(input logic [11:0] s);
    if (exp_q.size() == 0) cmp("event", 16'hFFFF, {4'h0, s});
    else cmp("event", {4'h0, exp_q.pop_front()}, {4'h0, s});
  endtask
  ////////////////////////////////////////////////////////////////
  // Watches the outputs, takes the oldest note per event
  always @(posedge mclk) begin
    req_p <= bus_req;
    rs_p <= bus_resel;
    if (!rst && bus_resel && !rs_p) chk({4'h5, 5'h00, bus_resel_id});
    if (!rst && bus_req && !req_p && bus_data_oe) chk({1'b0, bus_phase, bus_data_out});
    if (!rst && rx_valid) chk({rx_to_dma, bus_phase, rx_data});
  end
  ////////////////////////////////////////////////////////////////
  task automatic step;
    @(posedge mclk);
    #1;
  endtask
  task automatic issue(input logic [7:0] c);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    @(posedge mclk);
    cmd_valid <= 1'b0;
  endtask
  function automatic logic sel(input int s);
    case (s)
      0: return cmd_done;
      1: return cmd_reject;
      2: return pause_done;
      3: return setup_valid;
      4: return halted;
      default: return !halted;
    endcase
  endfunction
  // Bounded wait so a lost pulse cannot hang the run
  task automatic wt(input int s, input int lim, input string nm);
    int j;
    #1;
    for (j = 0; j < lim && sel(s) !== 1'b1; j++) step;
    cmp(nm, 16'h0001, {15'h0000, j < lim});
  endtask
  task automatic put(input logic d, input logic [7:0] v);
    int j;
    @(posedge mclk);
    if (d) {dma_valid, dma_data} <= {1'b1, v};
    else {tx_valid, tx_data} <= {1'b1, v};
    for (j = 0; j < 400; j++) begin
      @(posedge mclk);
      if ((d ? dma_ready : tx_ready) === 1'b1) break;
    end
    {tx_valid, dma_valid} <= 2'h0;
  endtask
  task automatic load(input logic d, input logic [2:0] ph);
    logic [7:0] v;
    v = 8'($random(seed));
    exp_q.push_back({1'b0, ph, v});
    put(d, v);
  endtask
  task automatic setl(input logic [7:0] m, input logic [7:0] by, input logic [2:0] id);
    @(posedge mclk);
    msg_cmd_byte_count <= m;
    data_block_count <= 8'h00;
    data_byte_count <= by;
    target_peer_identifier <= id;
  endtask
  task automatic tx_cmd(input logic [7:0] c, input logic [2:0] ph, input int cnt);
    repeat (cnt) load(1'b0, ph);
    issue(c);
    if (cnt == 8) begin
      issue(8'h36);
      wt(1, 4, "reject");
    end
    wt(0, 3000, "done");
  endtask
  task automatic rx_cmd(input logic [7:0] c, input logic [2:0] ph, input int cnt,
                        input logic [7:0] v);
    @(posedge mclk);
    pat <= v;
    repeat (cnt) exp_q.push_back({c == 8'h37, ph, v});
    issue(c);
    wt(0, 3000, "done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    fails++;
    summarize;
  end
  initial begin
    seed = 32'h0000B2AC;
    {rst, cmd_valid, tx_valid, dma_valid, slow} = 5'h10;
    {cmd_code, msg_cmd_byte_count, data_block_count, data_byte_count} = 32'h00000000;
    {tx_data, dma_data, pat, target_peer_identifier} = 27'h0000000;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    issue(8'h43);
    wt(3, 4, "setup_valid");
    for (k = 0; k < 3; k++) begin
      issue(8'(8'h44 + k));
      wt(0, 4, "done");
      cmp("diag_mode", 16'((k + 1) % 3), {14'h0000, diag_mode});
    end
    issue(8'h48);
    wt(0, 4, "done");
    cmp("bus_rst", 16'h0001, {15'h0000, bus_rst});
    issue(8'h49);
    wt(0, 4, "done");
    cmp("bus_rst", 16'h0000, {15'h0000, bus_rst});
    issue(8'h42);
    #1;
    for (i = 0; i < 50 && bus_rst !== 1'b1; i++) step;
    for (n = 0; n < 50 && bus_rst === 1'b1; n++) step;
    cmp("rst_len", 16'h0014, 16'(n));
    issue(8'h41);
    wt(0, 4, "done");
    issue(8'h47);
    wt(2, 4, "pause_done");
    foreach (rej[j]) begin
      issue(rej[j]);
      wt(1, 4, "reject");
    end
    tx_cmd(8'h38, `SCD_PH_MIN, 1);
    tx_cmd(8'h3A, `SCD_PH_STAT, 1);
    setl(8'h02, 8'h08, 3'h0);
    slow <= 1'b1;
    tx_cmd(8'h34, `SCD_PH_DIN, 8);
    cmp("tx_ready", 16'h0001, {15'h0000, tx_ready});
    setl(8'h02, 8'h03, 3'h0);
    issue(8'h35);
    repeat (3) load(1'b1, `SCD_PH_DIN);
    wt(0, 3000, "done");
    slow <= 1'b0;
    for (k = 0; k < 2; k++) begin
      b = 8'($random(seed));
      setl(8'h02, 8'h00, b[2:0]);
      exp_q.push_back({4'h5, 5'h00, b[2:0]});
      for (i = 0; i < 4; i++) load(1'b0, (i == 2) ? `SCD_PH_STAT : `SCD_PH_MIN);
      issue(8'(8'h2A + k));
      wt(0, 3000, "done");
      cmp("bus_bsy", 16'(k), {15'h0000, bus_bsy});
    end
    tx_cmd(8'h2C, `SCD_PH_MIN, 1);
    cmp("bus_bsy", 16'h0000, {15'h0000, bus_bsy});
    setl(8'h21, 8'h02, 3'h0);
    rx_cmd(8'h39, `SCD_PH_MOUT, 1, 8'($random(seed)));
    rx_cmd(8'h29, `SCD_PH_MOUT, 33, 8'($random(seed)));
    rx_cmd(8'h28, `SCD_PH_CMD, 33, 8'($random(seed)));
    rx_cmd(8'h36, `SCD_PH_DOUT, 2, 8'($random(seed)));
    rx_cmd(8'h37, `SCD_PH_DOUT, 2, 8'($random(seed)));
    // Pause in a data phase: one byte finishes, then pause_done without done
    exp_q.push_back({1'b0, `SCD_PH_DOUT, pat});
    issue(8'h36);
    issue(8'h47);
    cmp("busy", 16'h0001, {15'h0000, busy});
    wt(2, 100, "pause_done");
    cmp("busy", 16'h0000, {15'h0000, busy});
    for (k = 0; k < 4; k++) begin
      b = 8'($random(seed));
      n = (b[7:5] == 3'h1 || b[7:5] == 3'h2) ? 10 : ((b[7:5] == 3'h5) ? 12 : 6);
      rx_cmd(8'h3B, `SCD_PH_CMD, n, b);
    end
    setl(8'h21, 8'h02, 3'h6);
    exp_q.push_back({4'h5, 5'h00, 3'h6});
    issue(8'h30);
    wt(0, 100, "done");
    cmp("bus_bsy", 16'h0001, {15'h0000, bus_bsy});
    issue(8'h33);
    wt(0, 4, "done");
    cmp("bus_bsy", 16'h0000, {15'h0000, bus_bsy});
    for (k = 0; k < 2; k++) begin
      issue(8'(8'h31 + k));
      wt(0, 4, "done");
      cmp("bus_req", 16'(1 - k), {15'h0000, bus_req});
    end
    issue(8'h40);
    wt(4, 4, "halted");
    issue(8'h38);
    wt(1, 4, "reject");
    issue(8'h40);
    wt(5, 4, "ready");
    step;
    cmp("left", 16'h0000, 16'(exp_q.size()));
    summarize;
  end
endmodule
